//--- src/cdap_top.sv
// Codec digital audio serial port with Wishbone register slave
// What this block does
// - Every sample word moves most significant bit first, least significant bit last.
// - Format field bits 9:8 picks right, left, I2S or DSP; resets to I2S.
// - Word length bits 11:10 pick 16/20/24/32, reset 24; right justified caps 24.
// - Bit 13 floats word clock, bit clock and capture data drivers.
// - Bit 12 inverts word clock, or picks DSP mode A/B.
// - Left justified: MSB on first rising edge after word clock change.
// - Right justified: LSB on last rising edge before word clock change.
// - I2S: MSB on second rising edge after word clock change.
// - DSP: right word follows left word directly; idle clocks may trail.
// - Capture register bit 7 turns on pull-down of capture data pin.
// - Playback register bit 7 turns on pull-down of playback data pin.
// - Capture bits 6 and 5 choose converter channel for the left and right sent words.
// - Playback bits 6 and 5 choose received channel for each output.
// - Capture bit 3 enables two-slot multiplexing on capture data.
// - Capture bit 4 picks slot 0 or 1 for capture data.
// - Playback bit 3 enables two-slot multiplexing on playback data.
// - Playback bit 4 picks slot 0 or 1 for playback data.
// - In multiplexed capture, drive data pin only in own slot, else float.
// - Master drives both clocks; slave takes both from the host.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cdap_defines.svh"

module cdap_top (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Link pins
   input  wire logic        bclk_i,
   output logic             bclk_o,
   output logic             bclk_oe_o,
   input  wire logic        lrclk_i,
   output logic             lrclk_o,
   output logic             lrclk_oe_o,
   output logic             capture_serial_out_o,
   output logic             capture_serial_out_oe_o,
   output logic             capture_pin_pulldown_o,
   input  wire logic        playback_serial_in_i,
   output logic             playback_pin_pulldown_o,
   // Converter side
   input  wire logic [31:0] adc_left_i,
   input  wire logic [31:0] adc_right_i,
   output logic      [31:0] dac_left_o,
   output logic      [31:0] dac_right_o,
   output logic             dac_valid_o
);
   import cdap_pkg::*;

   cdap_state_t s;
   cdap_state_t n;

   function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0]  sel);
      lane_merge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
   endfunction : lane_merge

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic        dsp;
      logic        i2s;
      logic        rj;
      logic        inv;
      logic        lrinv;
      logic        tdm_c;
      logic        tdm_p;
      logic        eb;
      logic        el;
      logic        rise;
      logic        fall;
      logic        trans;
      logic        load;
      logic        chan;
      logic        own;
      logic [7:0]  wl;
      logic [7:0]  nw;
      logic [7:0]  span;
      logic [7:0]  start;
      logic [7:0]  tcn;
      logic [31:0] word_in;
      logic [15:0] rd;
      n       = s;
      dsp     = s.fmt[`CDAP_FMT_HI:`CDAP_FMT_LO] == CDAP_DSP;
      i2s     = s.fmt[`CDAP_FMT_HI:`CDAP_FMT_LO] == CDAP_I2S;
      rj      = s.fmt[`CDAP_FMT_HI:`CDAP_FMT_LO] == CDAP_RJ;
      inv     = s.fmt[`CDAP_BCLK_INV];
      lrinv   = s.fmt[`CDAP_LR_INV];
      tdm_c   = s.cap[`CDAP_TDM];
      tdm_p   = s.pb[`CDAP_TDM];
      trans   = 1'b0;
      load    = 1'b0;
      chan    = 1'b0;
      tcn     = s.tc;
      start   = 8'h00;
      word_in = 32'h0000_0000;
      rd      = 16'h0000;
      // Right justified cannot carry 32 bits; code 11 falls back to 24
      unique case (s.fmt[`CDAP_WL_HI:`CDAP_WL_LO])
         2'b00:   wl = 8'h10;
         2'b01:   wl = 8'h14;
         2'b10:   wl = 8'h18;
         default: wl = rj ? 8'h18 : 8'h20;
      endcase
      nw   = dsp ? (tdm_c | tdm_p ? 8'h04 : 8'h02) : (tdm_c | tdm_p ? 8'h02 : 8'h01);
      span = 8'(wl * nw);

      // Register bus: answer one cycle after the request, unmapped reads zero
      n.ack  = 1'b0;
      n.dval = 1'b0;
      if (wb_cyc_i && wb_stb_i && !s.ack) begin
         n.ack = 1'b1;
         unique case (wb_adr_i[11:2])
            `CDAP_IDX_FMT: begin
               rd = s.fmt;
               if (wb_we_i) n.fmt = lane_merge(s.fmt, wb_dat_i, wb_sel_i);
            end
            `CDAP_IDX_CAP: begin
               rd = s.cap;
               if (wb_we_i) n.cap = lane_merge(s.cap, wb_dat_i, wb_sel_i);
            end
            `CDAP_IDX_PB: begin
               rd = s.pb;
               if (wb_we_i) n.pb = lane_merge(s.pb, wb_dat_i, wb_sel_i);
            end
            `CDAP_IDX_MODE: begin
               rd = {15'h0000, s.master};
               if (wb_we_i && wb_sel_i[0]) n.master = wb_dat_i[`CDAP_MASTER];
            end
            `CDAP_IDX_STAT: rd = {12'h000, s.lrlast, s.eprev, s.act, s.master};
            default:        rd = 16'h0000;
         endcase
         n.rdat = rd;
      end

      ////////////////////////////////////////////////////////////////////////
      // Pin inputs: three flops, a level counts once stages two and three agree
      n.bs1 = bclk_i;
      n.bs2 = s.bs1;
      n.bs3 = s.bs2;
      n.ls1 = lrclk_i;
      n.ls2 = s.ls1;
      n.ls3 = s.ls2;
      n.ds1 = playback_serial_in_i;
      n.ds2 = s.ds1;
      n.ds3 = s.ds2;
      if (s.bs2 == s.bs3) n.bst = s.bs3;
      if (s.ls2 == s.ls3) n.lst = s.ls3;
      if (s.ds2 == s.ds3) n.dst = s.ds3;

      // Master clock generator; word clock moves with the falling bit clock
      if (s.master) begin
         if (s.div == 3'(`CDAP_BCLK_HALF_CYC - 1)) begin
            n.div = 3'h0;
            n.gen = !s.gen;
            if (s.gen) begin
               n.fc    = s.fc + 7'h01;
               n.lrgen = dsp ? (n.fc == 7'h00) : n.fc[6];
            end
         end else begin
            n.div = s.div + 3'h1;
         end
      end else begin
         n.div   = 3'h0;
         n.gen   = 1'b0;
         n.fc    = 7'h00;
         n.lrgen = 1'b0;
      end

      // Effective levels after polarity settings
      eb     = s.master ? s.gen : (s.bst ^ inv);
      el     = s.master ? s.lrgen : (s.lst ^ (lrinv & !dsp));
      rise   = eb & !s.eprev;
      fall   = !eb & s.eprev;
      n.eprev = eb;

      ////////////////////////////////////////////////////////////////////////
      // Launch side: everything moves on the falling edge
      if (fall) begin
         n.lrlast = el;
         trans    = dsp ? (el & !s.lrlast) : (el != s.lrlast);
         tcn      = trans ? 8'h00 : (s.tc == 8'hFF ? s.tc : s.tc + 8'h01);
         n.tc     = tcn;
         if (trans) n.half = (s.tc == 8'hFF) ? s.tc : s.tc + 8'h01;
         if (rj) begin
            start = (s.half > span) ? s.half - span : 8'h00;
         end else if (i2s || (dsp && !lrinv)) begin
            start = 8'h01;
         end else begin
            start = 8'h00;
         end
         if (tcn == start) begin
            n.act  = 1'b1;
            n.bitc = 5'h00;
            n.word = 2'h0;
            load   = 1'b1;
         end else if (s.act) begin
            if (s.bitc == 5'(wl - 8'h01)) begin
               if (s.word == 2'(nw - 8'h01)) begin
                  n.act = 1'b0;
               end else begin
                  n.word = s.word + 2'h1;
                  n.bitc = 5'h00;
                  load   = 1'b1;
               end
            end else begin
               n.bitc = s.bitc + 5'h01;
               n.tx   = {s.tx[30:0], 1'b0};
            end
         end
         if (load) begin
            if (dsp) begin
               n.wslot = n.word[1];
               chan    = n.word[0];
            end else begin
               n.wslot = n.word[0];
               chan    = i2s ? el : !el;
            end
            n.wchan = chan;
            // Samples are held MSB aligned, so the top bit goes out first
            if (chan ? s.cap[`CDAP_RSRC] : s.cap[`CDAP_LSRC]) begin
               n.tx = adc_right_i;
            end else begin
               n.tx = adc_left_i;
            end
         end
      end

      // Capture side: sample on the rising edge inside own playback slot
      // Without playback multiplexing only slot 0 is taken, even if capture uses two
      if (rise && s.act && (s.wslot == (tdm_p & s.pb[`CDAP_SLOT]))) begin
         word_in = {s.rx[30:0], s.dst};
         n.rx    = word_in;
         if (s.bitc == 5'(wl - 8'h01)) begin
            word_in = word_in << (6'h20 - 6'(wl));
            if (s.wchan) n.rxr = word_in;
            else         n.rxl = word_in;
            n.dval = 1'b1;
         end
      end
      n.dacl = n.pb[`CDAP_LSRC] ? n.rxr : n.rxl;
      n.dacr = n.pb[`CDAP_RSRC] ? n.rxr : n.rxl;

      ////////////////////////////////////////////////////////////////////////
      // Pin drivers
      own       = !tdm_c || (n.wslot == n.cap[`CDAP_SLOT]);
      n.sdo     = (n.act && own) ? n.tx[31] : 1'b0;
      n.sdo_oe  = !n.fmt[`CDAP_TRI] && (!tdm_c || (n.act && own));
      n.bclk_o  = n.gen ^ n.fmt[`CDAP_BCLK_INV];
      n.lr_o    = n.lrgen ^ (n.fmt[`CDAP_LR_INV] && !dsp);
      n.bclk_oe = n.master && !n.fmt[`CDAP_TRI];
      n.lr_oe   = n.master && !n.fmt[`CDAP_TRI];
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s     <= '0;
         s.fmt <= `CDAP_RST_FMT;
         s.cap <= `CDAP_RST_CAP;
         s.pb  <= `CDAP_RST_PB;
      end else begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign wb_dat_o                = {16'h0000, s.rdat};
   assign wb_ack_o                = s.ack;
   assign bclk_o                  = s.bclk_o;
   assign bclk_oe_o               = s.bclk_oe;
   assign lrclk_o                 = s.lr_o;
   assign lrclk_oe_o              = s.lr_oe;
   assign capture_serial_out_o    = s.sdo;
   assign capture_serial_out_oe_o = s.sdo_oe;
   assign capture_pin_pulldown_o  = s.cap[`CDAP_PD];
   assign playback_pin_pulldown_o = s.pb[`CDAP_PD];
   assign dac_left_o              = s.dacl;
   assign dac_right_o             = s.dacr;
   assign dac_valid_o             = s.dval;

endmodule : cdap_top
`default_nettype wire

//--- inc/cdap_defines.svh
// Register map, field positions, reset values and timing counts of the audio port
`ifndef CDAP_DEFINES_SVH
`define CDAP_DEFINES_SVH

`define CDAP_IDX_FMT        10'h070
`define CDAP_IDX_CAP        10'h072
`define CDAP_IDX_PB         10'h073
`define CDAP_IDX_MODE       10'h074
`define CDAP_IDX_STAT       10'h075

`define CDAP_BCLK_INV       15
`define CDAP_TRI            13
`define CDAP_LR_INV         12
`define CDAP_WL_HI          11
`define CDAP_WL_LO          10
`define CDAP_FMT_HI         9
`define CDAP_FMT_LO         8
`define CDAP_PD             7
`define CDAP_LSRC           6
`define CDAP_RSRC           5
`define CDAP_SLOT           4
`define CDAP_TDM            3
`define CDAP_MASTER         0

`define CDAP_RST_FMT        16'h0A00
`define CDAP_RST_CAP        16'h0020
`define CDAP_RST_PB         16'h0020

`define CDAP_CLK_NS         50
`define CDAP_BCLK_HALF_NS   200
`define CDAP_BCLK_HALF_CYC  (`CDAP_BCLK_HALF_NS / `CDAP_CLK_NS)
`define CDAP_FRAME_BCLKS    8'h80

`endif

//--- inc/cdap_pkg.sv
// Types used by the audio port design; its bench does not import them
package cdap_pkg;

   typedef enum logic [1:0] {
      CDAP_RJ,
      CDAP_LJ,
      CDAP_I2S,
      CDAP_DSP
   } cdap_fmt_t;

   typedef struct packed {
      logic        ack;
      logic [15:0] rdat;
      logic [15:0] fmt;
      logic [15:0] cap;
      logic [15:0] pb;
      logic        master;
      logic        bs1, bs2, bs3, bst;
      logic        ls1, ls2, ls3, lst;
      logic        ds1, ds2, ds3, dst;
      logic [2:0]  div;
      logic        gen;
      logic [6:0]  fc;
      logic        lrgen;
      logic        eprev;
      logic        lrlast;
      logic [7:0]  tc;
      logic [7:0]  half;
      logic        act;
      logic [4:0]  bitc;
      logic [1:0]  word;
      logic        wchan;
      logic        wslot;
      logic [31:0] tx;
      logic [31:0] rx;
      logic [31:0] rxl;
      logic [31:0] rxr;
      logic [31:0] dacl;
      logic [31:0] dacr;
      logic        dval;
      logic        bclk_o;
      logic        bclk_oe;
      logic        lr_o;
      logic        lr_oe;
      logic        sdo;
      logic        sdo_oe;
   } cdap_state_t;

endpackage : cdap_pkg

//--- tb/cdap_monitor.sv
// Assertion checker for the audio port, watching only its pins
`timescale 1ns/1ps
`default_nettype none
`include "cdap_defines.svh"
module cdap_monitor (
   // Clock, reset and register bus
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Link pins
   input wire logic        bclk_i,
   input wire logic        bclk_oe_o,
   input wire logic        lrclk_oe_o,
   input wire logic        capture_serial_out_o,
   input wire logic        capture_serial_out_oe_o,
   input wire logic        capture_pin_pulldown_o,
   input wire logic        playback_pin_pulldown_o
);
   logic [15:0] fmt_q, cap_q, pb_q;
   logic        mode_q, last_q, rd, wr;
   logic [3:0]  idle_q;
   logic [9:0]  idx;
   assign idx = wb_adr_i[11:2];
   assign rd  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
   assign wr  = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
   function automatic logic [15:0] mix(input logic [15:0] o);
      return {wb_sel_i[1] ? wb_dat_i[15:8] : o[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : o[7:0]};
   endfunction : mix
   // Shadow copies of the registers, updated at the edge that takes a write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fmt_q  <= `CDAP_RST_FMT;
         cap_q  <= `CDAP_RST_CAP;
         pb_q   <= `CDAP_RST_PB;
         mode_q <= 1'b0;
         idle_q <= 4'h0;
      end else begin
         if (wr && idx == `CDAP_IDX_FMT) fmt_q <= mix(fmt_q);
         if (wr && idx == `CDAP_IDX_CAP) cap_q <= mix(cap_q);
         if (wr && idx == `CDAP_IDX_PB) pb_q <= mix(pb_q);
         if (wr && idx == `CDAP_IDX_MODE && wb_sel_i[0]) mode_q <= wb_dat_i[0];
         if (bclk_i != last_q) idle_q <= 4'h0;
         else if (idle_q != 4'hf) idle_q <= idle_q + 4'h1;
      end
      last_q <= bclk_i;
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_fmt_read: assert property (
      rd && idx == `CDAP_IDX_FMT |=> wb_ack_o && wb_dat_o == {16'h0000, fmt_q})
      else $error("format register read wrong");
   a_cap_read: assert property (
      rd && idx == `CDAP_IDX_CAP |=> wb_ack_o && wb_dat_o == {16'h0000, cap_q})
      else $error("capture register read wrong");
   a_pb_read: assert property (
      rd && idx == `CDAP_IDX_PB |=> wb_ack_o && wb_dat_o == {16'h0000, pb_q})
      else $error("playback register read wrong");
   a_cap_pull: assert property (
      capture_pin_pulldown_o == cap_q[`CDAP_PD]) else $error("capture pull-down wrong");
   a_pb_pull: assert property (
      playback_pin_pulldown_o == pb_q[`CDAP_PD]) else $error("playback pull-down wrong");
   a_tri_float: assert property (
      fmt_q[`CDAP_TRI] && $past(fmt_q[`CDAP_TRI])
      |-> !bclk_oe_o && !lrclk_oe_o && !capture_serial_out_oe_o)
      else $error("driver enabled while floated");
   a_slave_quiet: assert property (
      !mode_q && !$past(mode_q) |-> !bclk_oe_o && !lrclk_oe_o)
      else $error("slave drives a link clock");
   a_idle_still: assert property (
      idle_q == 4'hf |-> $stable(capture_serial_out_o))
      else $error("capture data moved without bit clock");
endmodule : cdap_monitor
`default_nettype wire

//--- tb/cdap_host.sv
// Host serial port model: makes both link clocks, sends and samples words
`timescale 1ns/1ps
`default_nettype none
module cdap_host (
   // Link pins
   output logic      bclk_o,
   output logic      lrclk_o,
   output logic      sd_o,
   input  wire logic cd_i
);
   logic [31:0] rx [2];
   initial begin
      bclk_o  = 1'b1;
      lrclk_o = 1'b1;
      sd_o    = 1'b0;
   end
   // 32 bit clocks a half, left half low, 16-bit words from ofs clocks on
   task automatic frame(input logic [31:0] l, input logic [31:0] r, input int ofs);
      int b;
      #7;
      // Lead-in bit clock at the old word clock level, so a format change is seen
      bclk_o <= 1'b0;
      #200;
      bclk_o <= 1'b1;
      #200;
      for (int h = 0; h < 2; h++) begin
         for (int p = 0; p < 32; p++) begin
            b = 31 - p + ofs;
            bclk_o <= 1'b0;
            if (p == 0) lrclk_o <= h[0];
            if (b > 15 && b < 32) sd_o <= (h != 0) ? r[b] : l[b];
            else sd_o <= ~sd_o;
            #200;
            bclk_o <= 1'b1;
            #199;
            // Synchroniser delay puts the launch past the rise, so sample late
            if (b > 15 && b < 32) rx[h][b] = cd_i;
            #1;
         end
      end
   endtask : frame
endmodule : cdap_host
`default_nettype wire

//--- tb/testbench.sv
// Bench for the audio port: register access and framed link traffic
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0, wb_ack_o, bclk_o, bclk_oe_o, lrclk_o, lrclk_oe_o;
   logic        capture_serial_out_o, capture_serial_out_oe_o, dac_valid_o;
   logic        capture_pin_pulldown_o, playback_pin_pulldown_o;
   logic [11:0] wb_adr_i = 12'h000;
   logic [3:0]  wb_sel_i = 4'h3;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, dac_left_o, dac_right_o;
   logic [31:0] adc_left_i = 32'hA5C3_0000, adc_right_i = 32'h3C96_0000;
   wire logic   host_bclk, host_lrclk, cap_w, bclk_i, lrclk_i, playback_serial_in_i;
   int          err_count = 0, cmp_count = 0, dv_count = 0;
   // fmt, cap, pb, capture left/right, dac left/right
   localparam logic [15:0] TAB [5][7] = '{
      '{16'h0200, 16'h0020, 16'h0020, 16'hA5C3, 16'h3C96, 16'h5A17, 16'hC3E9},
      '{16'h1100, 16'h0020, 16'h0020, 16'hA5C3, 16'h3C96, 16'h5A17, 16'hC3E9},
      '{16'h0200, 16'h0040, 16'h0040, 16'h3C96, 16'hA5C3, 16'hC3E9, 16'h5A17},
      '{16'h2200, 16'h0020, 16'h0020, 16'hFFFF, 16'hFFFF, 16'h5A17, 16'hC3E9},
      '{16'h0200, 16'h0038, 16'h0020, 16'hFFFF, 16'hFFFF, 16'h5A17, 16'hC3E9}};
   assign bclk_i  = bclk_oe_o ? bclk_o : host_bclk;
   assign lrclk_i = lrclk_oe_o ? lrclk_o : host_lrclk;
   assign cap_w   = capture_serial_out_oe_o ? capture_serial_out_o : ~capture_pin_pulldown_o;
   cdap_top cdap_top_inst (.*);
   cdap_host cdap_host_inst (.bclk_o(host_bclk), .lrclk_o(host_lrclk),
                             .sd_o(playback_serial_in_i), .cd_i(cap_w));
   always #25 clk_i = ~clk_i;
   always @(negedge clk_i) if (dac_valid_o === 1'b1) dv_count++;
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic we, input logic [11:0] a, input logic [15:0] d,
                       output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= {16'h0000, d};
      // Ack is looked at between edges; the request stands until the edge after it
      do @(negedge clk_i); while (wb_ack_o !== 1'b1);
      @(posedge clk_i);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : xfer
   task automatic rd(input logic [11:0] a, input logic [15:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 16'h0000, q);
      chk(q, {16'h0000, e});
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask : wr
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(12'h1C0, 16'h0A00);
      rd(12'h1C8, 16'h0020);
      rd(12'h1CC, 16'h0020);
      wr(12'h000, 16'hFFFF);
      rd(12'h000, 16'h0000);
      wr(12'h1C8, 16'h0080);
      chk(capture_pin_pulldown_o, 32'h0000_0001);
      wr(12'h1CC, 16'h0080);
      chk(playback_pin_pulldown_o, 32'h0000_0001);
      for (int i = 0; i < 5; i++) begin
         wr(12'h1C0, TAB[i][0]);
         wr(12'h1C8, TAB[i][1]);
         wr(12'h1CC, TAB[i][2]);
         rd(12'h1C0, TAB[i][0]);
         dv_count = 0;
         cdap_host_inst.frame(32'h5A17_0000, 32'hC3E9_0000, TAB[i][0][9]);
         chk(dv_count, 32'h0000_0002);
         chk(cdap_host_inst.rx[0] >> 16, TAB[i][3]);
         chk(cdap_host_inst.rx[1] >> 16, TAB[i][4]);
         chk(dac_left_o, {TAB[i][5], 16'h0000});
         chk(dac_right_o, {TAB[i][6], 16'h0000});
      end
      wr(12'h1D0, 16'h0001);
      rd(12'h1D0, 16'h0001);
      chk(bclk_oe_o, 32'h0000_0001);
      chk(lrclk_oe_o, 32'h0000_0001);
      wr(12'h1D0, 16'h0000);
      chk(bclk_oe_o, 32'h0000_0000);
      chk(lrclk_oe_o, 32'h0000_0000);
      report_and_stop();
   end
   initial begin
      #400000;
      err_count++;
      report_and_stop();
   end
endmodule : testbench
bind cdap_top cdap_monitor cdap_monitor_inst (.*);
`default_nettype wire
